// ---- src/cce_debounce.v ----
`include "cce_map.vh"

module cce_debounce #(
	parameter DEB_CYC = `CCE_DEB_MS * `CCE_CYC_PER_MS
) (
	input wire pclk,
	input wire presetn,
	input wire sw_n,
	output reg press_reg
);

reg sync1_reg;
reg sync2_reg;
reg stable_reg;
reg [31:0] cnt_reg;

// Level must stay changed for DEB_CYC before it counts
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		sync1_reg <= 1'b1;
		sync2_reg <= 1'b1;
		stable_reg <= 1'b1;
		cnt_reg <= 32'h0;
		press_reg <= 1'b0;
	end else begin
		sync1_reg <= sw_n;
		sync2_reg <= sync1_reg;
		press_reg <= 1'b0;
		if (sync2_reg == stable_reg) begin
			cnt_reg <= 32'h0;
		end else if (cnt_reg == DEB_CYC - 1) begin
			cnt_reg <= 32'h0;
			stable_reg <= sync2_reg;
			press_reg <= ~sync2_reg;
		end else begin
			cnt_reg <= cnt_reg + 32'h1;
		end
	end
end

endmodule // cce_debounce

// ---- src/cce_map.vh ----
`ifndef CCE_MAP_VH
`define CCE_MAP_VH

// APB register byte offsets
`define CCE_A_CTRL 8'h00
`define CCE_A_STATUS 8'h04
`define CCE_A_ACTSEL 8'h08
`define CCE_A_DISPLAY 8'h0C
`define CCE_A_RDIDX 8'h10
`define CCE_A_RDDATA 8'h14
`define CCE_A_ACTDATA 8'h18

// Field positions
`define CCE_CTRL_START 0
`define CCE_CTRL_FACTORY 1
`define CCE_ST_BUSY 4
`define CCE_ST_ERROR 5
`define CCE_ST_STORED 6

// Timing, figures in ms at the clock rate in MHz
`define CCE_CLK_MHZ 100
`define CCE_CYC_PER_MS (`CCE_CLK_MHZ * 1000)
`define CCE_SLOT_MS 3000
`define CCE_SHOW_MS 1000
`define CCE_DEB_MS 10

// Curve numbering and value limits (speed in units of 100 rpm)
`define CCE_CURVE_BASE 5'h0A
`define CCE_CURVE_LAST 3'h4
`define CCE_SPD_LIMIT 9'h12C
`define CCE_ANG_LIMIT 6'h27
`define CCE_TT_MAX 4'h2
`define CCE_ANG_TENS_MAX 4'h3
`define CCE_DIG_MAX 4'h9
`define CCE_PLAY_SPD_LAST 3'h4
`define CCE_LAST_ITEM 3'h7
`define CCE_FIRST_PARAM 3'h1

// States
`define CCE_S_IDLE 4'h0
`define CCE_S_CURVE 4'h1
`define CCE_S_PLAY 4'h2
`define CCE_S_PROMPT 4'h3
`define CCE_S_PARAM 4'h4
`define CCE_S_DIGIT 4'h5
`define CCE_S_CHECK 4'h6
`define CCE_S_ERROR 4'h7
`define CCE_S_STORED 4'h8

// Display symbol codes, 0 to 9 are the digits
`define CCE_SYM_BLANK 5'h0A
`define CCE_SYM_PROMPT 5'h0B
`define CCE_SYM_INVALID 5'h0C
`define CCE_SYM_STORED 5'h0D
`define CCE_SYM_SPEED 5'h0E
`define CCE_SYM_ANGLE 5'h0F

`endif

// ---- src/cce_menu.v ----
// Overview of operation
// - Power-up, and factory reset while idle, fill all custom curves 10-14 with preset curve one.
// - Edited curve reaches ignition only when selected again via curve select.
// - Offer curves 10 to 14 on 3 s slots; actuation picks shown curve.
// - Play back stored pairs speed0, angle0 up to speed3, angle3.
// - Speeds are shown as single digits one after another.
// - Actuation during an angle playback before validation skips straight to input phase.
// - Input phase starts with a prompt symbol.
// - Offer angle0 onward in order on 3 s slots; actuation picks one.
// - Angle entry: tens 0-3 then units 0-9, 3 s each, actuation latches.
// - Speed entry: ten-thousands 0-2, thousands 0-9, hundreds 0-9, latching.
// - After entry offer only later parameters; input ends after angle3 slot.
// - Invalid set shows error symbol and keeps the old values.
// - After validation play back new or kept values in same order.
// - Valid set is committed to storage and a stored symbol is shown.
// - Sequence ends back in normal mode showing engine speed.
// - Valid means rising speeds, speeds 1-3 below 30000, angles below 39.
// - speed0 stays zero and is never offered for editing.
// - Angles are entered in whole degrees.
`include "cce_map.vh"

module cce_menu #(
	parameter SLOT_CYC = `CCE_SLOT_MS * `CCE_CYC_PER_MS,
	parameter SHOW_CYC = `CCE_SHOW_MS * `CCE_CYC_PER_MS,
	parameter DEB_CYC = `CCE_DEB_MS * `CCE_CYC_PER_MS,
	parameter [8:0] PRE_S1 = 9'h028,
	parameter [8:0] PRE_S2 = 9'h064,
	parameter [8:0] PRE_S3 = 9'h0C8,
	parameter [5:0] PRE_A0 = 6'h0A,
	parameter [5:0] PRE_A1 = 6'h14,
	parameter [5:0] PRE_A2 = 6'h1C,
	parameter [5:0] PRE_A3 = 6'h19
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata_reg,
	output reg pready_reg,
	output reg pslverr_reg,
	input wire mag_sw_n,
	input wire [4:0] eng_disp_left,
	input wire [4:0] eng_disp_right,
	output reg [4:0] disp_left_reg,
	output reg [4:0] disp_right_reg,
	output reg menu_busy_reg,
	output reg nvm_commit_reg
);

////////////////////////////////////////////////////////////////////////////////
// Storage: speed entry 0 of every curve is held at zero

reg [8:0] spd_mem [0:19];
reg [5:0] ang_mem [0:19];
reg [8:0] wspd [0:3];
reg [5:0] wang [0:3];
reg [8:0] act_spd [0:3];
reg [5:0] act_ang [0:3];

reg [3:0] state_reg;
reg [2:0] cur_reg;
reg [2:0] item_reg;
reg [2:0] dig_reg;
reg [3:0] cand_reg;
reg [8:0] acc_reg;
reg [31:0] tmr_reg;
reg post_reg;
reg ok_reg;
reg err_flag_reg;
reg stored_flag_reg;
reg [4:0] act_num_reg;
reg [2:0] rd_curve_reg;
reg [2:0] rd_item_reg;
reg start_reg;
reg factory_reg;
reg [4:0] disp_l_next;
reg [4:0] disp_r_next;
reg [31:0] prdata_next;
reg addr_ok;

wire press;
wire is_slot = (state_reg == `CCE_S_CURVE) || (state_reg == `CCE_S_PARAM) ||
	(state_reg == `CCE_S_DIGIT);
wire [31:0] tmr_lim = is_slot ? SLOT_CYC - 1 : SHOW_CYC - 1;
wire tmr_done = (tmr_reg == tmr_lim);
wire is_speed = ~item_reg[0];
wire [4:0] mem_idx = {cur_reg, item_reg[2:1]};
wire [4:0] rd_idx = {rd_curve_reg, rd_item_reg[2:1]};
wire [8:0] pv_spd = spd_mem[mem_idx];
wire [5:0] pv_ang = ang_mem[mem_idx];
wire [8:0] sp_tt = pv_spd / 9'h064;
wire [8:0] sp_th = (pv_spd / 9'h00A) % 9'h00A;
wire [8:0] sp_hu = pv_spd % 9'h00A;
wire [5:0] an_te = pv_ang / 6'h0A;
wire [5:0] an_un = pv_ang % 6'h0A;
wire [12:0] acc_x = acc_reg * 4'hA + cand_reg;
wire [8:0] acc_new = acc_x[8:0];
wire dig_last = is_speed ? (dig_reg == 3'h2) : (dig_reg == 3'h1);
wire [3:0] cand_max = (dig_reg != 3'h0) ? `CCE_DIG_MAX :
	(is_speed ? `CCE_TT_MAX : `CCE_ANG_TENS_MAX);
wire apb_wr = psel & penable & pready_reg & pwrite;
wire [4:0] sel_num = pwdata[4:0];
wire sel_custom = (sel_num >= `CCE_CURVE_BASE) &&
	(sel_num <= `CCE_CURVE_BASE + {2'h0, `CCE_CURVE_LAST});
wire [4:0] sel_off = sel_num - `CCE_CURVE_BASE;
wire set_ok = (wspd[1] > wspd[0]) && (wspd[2] > wspd[1]) &&
	(wspd[3] > wspd[2]) && (wspd[3] < `CCE_SPD_LIMIT) &&
	(wang[0] < `CCE_ANG_LIMIT) && (wang[1] < `CCE_ANG_LIMIT) &&
	(wang[2] < `CCE_ANG_LIMIT) && (wang[3] < `CCE_ANG_LIMIT);

cce_debounce #(
	.DEB_CYC(DEB_CYC)
) u_deb (
	.pclk(pclk),
	.presetn(presetn),
	.sw_n(mag_sw_n),
	.press_reg(press)
);

////////////////////////////////////////////////////////////////////////////////
// APB slave, no wait state, yet every answer leaves a flop

always @* begin
	addr_ok = 1'b1;
	prdata_next = 32'h0;
	case (paddr)
	`CCE_A_CTRL: prdata_next = 32'h0;
	`CCE_A_STATUS: prdata_next = {25'h0, stored_flag_reg, err_flag_reg, menu_busy_reg,
		state_reg};
	`CCE_A_ACTSEL: prdata_next = {27'h0, act_num_reg};
	`CCE_A_DISPLAY: prdata_next = {19'h0, disp_left_reg, 3'h0, disp_right_reg};
	`CCE_A_RDIDX: prdata_next = {25'h0, rd_item_reg, 1'b0, rd_curve_reg};
	`CCE_A_RDDATA: prdata_next = rd_item_reg[0] ? {26'h0, ang_mem[rd_idx]} :
		{23'h0, spd_mem[rd_idx]};
	`CCE_A_ACTDATA: prdata_next = rd_item_reg[0] ? {26'h0, act_ang[rd_item_reg[2:1]]} :
		{23'h0, act_spd[rd_item_reg[2:1]]};
	default: addr_ok = 1'b0;
	endcase
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pready_reg <= 1'b0;
		prdata_reg <= 32'h0;
		pslverr_reg <= 1'b0;
		rd_curve_reg <= 3'h0;
		rd_item_reg <= 3'h0;
		start_reg <= 1'b0;
		factory_reg <= 1'b0;
	end else begin
		pready_reg <= psel & ~penable;
		pslverr_reg <= 1'b0;
		start_reg <= 1'b0;
		factory_reg <= 1'b0;
		if (psel & ~penable) begin
			prdata_reg <= pwrite ? 32'h0 : prdata_next;
			pslverr_reg <= ~addr_ok;
		end
		if (apb_wr && paddr == `CCE_A_CTRL) begin
			start_reg <= pwdata[`CCE_CTRL_START];
			factory_reg <= pwdata[`CCE_CTRL_FACTORY];
		end
		if (apb_wr && paddr == `CCE_A_RDIDX) begin
			rd_curve_reg <= pwdata[2:0];
			rd_item_reg <= pwdata[6:4];
		end
	end
end

// Active curve copy only moves on an explicit selection
always @(posedge pclk or negedge presetn) begin : act_blk
	integer i;
	if (!presetn) begin
		act_num_reg <= 5'h01;
		act_spd[0] <= 9'h000;
		act_spd[1] <= PRE_S1;
		act_spd[2] <= PRE_S2;
		act_spd[3] <= PRE_S3;
		act_ang[0] <= PRE_A0;
		act_ang[1] <= PRE_A1;
		act_ang[2] <= PRE_A2;
		act_ang[3] <= PRE_A3;
	end else if (apb_wr && paddr == `CCE_A_ACTSEL) begin
		act_num_reg <= sel_num;
		if (sel_custom) begin
			for (i = 0; i < 4; i = i + 1) begin
				act_spd[i] <= spd_mem[{sel_off[2:0], i[1:0]}];
				act_ang[i] <= ang_mem[{sel_off[2:0], i[1:0]}];
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Menu sequencer

always @(posedge pclk or negedge presetn) begin : seq_blk
	integer i;
	if (!presetn) begin
		state_reg <= `CCE_S_IDLE;
		cur_reg <= 3'h0;
		item_reg <= 3'h0;
		dig_reg <= 3'h0;
		cand_reg <= 4'h0;
		acc_reg <= 9'h000;
		tmr_reg <= 32'h0;
		post_reg <= 1'b0;
		ok_reg <= 1'b0;
		err_flag_reg <= 1'b0;
		stored_flag_reg <= 1'b0;
		nvm_commit_reg <= 1'b0;
		for (i = 0; i < 20; i = i + 1) begin
			spd_mem[i] <= (i % 4 == 1) ? PRE_S1 : (i % 4 == 2) ? PRE_S2 :
				(i % 4 == 3) ? PRE_S3 : 9'h000;
			ang_mem[i] <= (i % 4 == 0) ? PRE_A0 : (i % 4 == 1) ? PRE_A1 :
				(i % 4 == 2) ? PRE_A2 : PRE_A3;
		end
		for (i = 0; i < 4; i = i + 1) begin
			wspd[i] <= 9'h000;
			wang[i] <= 6'h00;
		end
	end else begin
		nvm_commit_reg <= 1'b0;
		tmr_reg <= tmr_done ? 32'h0 : tmr_reg + 32'h1;
		case (state_reg)
		`CCE_S_IDLE: begin
			tmr_reg <= 32'h0;
			if (factory_reg) begin
				for (i = 0; i < 20; i = i + 1) begin
					spd_mem[i] <= (i % 4 == 1) ? PRE_S1 : (i % 4 == 2) ? PRE_S2 :
						(i % 4 == 3) ? PRE_S3 : 9'h000;
					ang_mem[i] <= (i % 4 == 0) ? PRE_A0 : (i % 4 == 1) ? PRE_A1 :
						(i % 4 == 2) ? PRE_A2 : PRE_A3;
				end
			end else if (start_reg) begin
				state_reg <= `CCE_S_CURVE;
				cur_reg <= 3'h0;
				err_flag_reg <= 1'b0;
				stored_flag_reg <= 1'b0;
			end
		end
		`CCE_S_CURVE: begin
			if (press) begin
				state_reg <= `CCE_S_PLAY;
				tmr_reg <= 32'h0;
				item_reg <= 3'h0;
				dig_reg <= 3'h0;
				post_reg <= 1'b0;
				for (i = 0; i < 4; i = i + 1) begin
					wspd[i] <= spd_mem[{cur_reg, i[1:0]}];
					wang[i] <= ang_mem[{cur_reg, i[1:0]}];
				end
			end else if (tmr_done) begin
				if (cur_reg == `CCE_CURVE_LAST)
					state_reg <= `CCE_S_IDLE;
				else
					cur_reg <= cur_reg + 3'h1;
			end
		end
		`CCE_S_PLAY: begin
			if (press && !is_speed && !post_reg) begin
				state_reg <= `CCE_S_PROMPT;
				tmr_reg <= 32'h0;
			end else if (tmr_done) begin
				if (is_speed && dig_reg != `CCE_PLAY_SPD_LAST) begin
					dig_reg <= dig_reg + 3'h1;
				end else if (item_reg != `CCE_LAST_ITEM) begin
					item_reg <= item_reg + 3'h1;
					dig_reg <= 3'h0;
				end else if (!post_reg) begin
					state_reg <= `CCE_S_PROMPT;
				end else if (ok_reg) begin
					state_reg <= `CCE_S_STORED;
				end else begin
					state_reg <= `CCE_S_IDLE;
				end
			end
		end
		`CCE_S_PROMPT: begin
			if (tmr_done) begin
				state_reg <= `CCE_S_PARAM;
				item_reg <= `CCE_FIRST_PARAM;
			end
		end
		`CCE_S_PARAM: begin
			if (press) begin
				state_reg <= `CCE_S_DIGIT;
				tmr_reg <= 32'h0;
				dig_reg <= 3'h0;
				cand_reg <= 4'h0;
				acc_reg <= 9'h000;
			end else if (tmr_done) begin
				if (item_reg == `CCE_LAST_ITEM)
					state_reg <= `CCE_S_CHECK;
				else
					item_reg <= item_reg + 3'h1;
			end
		end
		`CCE_S_DIGIT: begin
			if (press) begin
				tmr_reg <= 32'h0;
				acc_reg <= acc_new;
				dig_reg <= dig_reg + 3'h1;
				cand_reg <= 4'h0;
				if (dig_last) begin
					if (is_speed)
						wspd[item_reg[2:1]] <= acc_new;
					else
						wang[item_reg[2:1]] <= acc_new[5:0];
					state_reg <= (item_reg == `CCE_LAST_ITEM) ? `CCE_S_CHECK :
						`CCE_S_PARAM;
					item_reg <= (item_reg == `CCE_LAST_ITEM) ? item_reg :
						item_reg + 3'h1;
				end
			end else if (tmr_done) begin
				if (cand_reg != cand_max) begin
					cand_reg <= cand_reg + 4'h1;
				end else begin
					// Unfinished entry leaves the parameter as it was
					state_reg <= (item_reg == `CCE_LAST_ITEM) ? `CCE_S_CHECK :
						`CCE_S_PARAM;
					item_reg <= (item_reg == `CCE_LAST_ITEM) ? item_reg :
						item_reg + 3'h1;
				end
			end
		end
		`CCE_S_CHECK: begin
			tmr_reg <= 32'h0;
			ok_reg <= set_ok;
			post_reg <= 1'b1;
			item_reg <= 3'h0;
			dig_reg <= 3'h0;
			if (set_ok) begin
				for (i = 1; i < 4; i = i + 1)
					spd_mem[{cur_reg, i[1:0]}] <= wspd[i];
				for (i = 0; i < 4; i = i + 1)
					ang_mem[{cur_reg, i[1:0]}] <= wang[i];
				nvm_commit_reg <= 1'b1;
				stored_flag_reg <= 1'b1;
				state_reg <= `CCE_S_PLAY;
			end else begin
				err_flag_reg <= 1'b1;
				state_reg <= `CCE_S_ERROR;
			end
		end
		`CCE_S_ERROR: begin
			if (tmr_done)
				state_reg <= `CCE_S_PLAY;
		end
		`CCE_S_STORED: begin
			if (tmr_done)
				state_reg <= `CCE_S_IDLE;
		end
		default: state_reg <= `CCE_S_IDLE;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// Display, registered so the pins never glitch

always @* begin
	disp_l_next = `CCE_SYM_BLANK;
	disp_r_next = `CCE_SYM_BLANK;
	case (state_reg)
	`CCE_S_IDLE: begin
		disp_l_next = eng_disp_left;
		disp_r_next = eng_disp_right;
	end
	`CCE_S_CURVE: begin
		disp_l_next = 5'h01;
		disp_r_next = {2'h0, cur_reg};
	end
	`CCE_S_PLAY: begin
		if (is_speed) begin
			disp_l_next = `CCE_SYM_SPEED;
			case (dig_reg)
			3'h0: disp_r_next = {1'b0, sp_tt[3:0]};
			3'h1: disp_r_next = {1'b0, sp_th[3:0]};
			3'h2: disp_r_next = {1'b0, sp_hu[3:0]};
			default: disp_r_next = 5'h00;
			endcase
		end else begin
			disp_l_next = {1'b0, an_te[3:0]};
			disp_r_next = {1'b0, an_un[3:0]};
		end
	end
	`CCE_S_PROMPT: begin
		disp_l_next = `CCE_SYM_PROMPT;
		disp_r_next = `CCE_SYM_PROMPT;
	end
	`CCE_S_PARAM: begin
		disp_l_next = is_speed ? `CCE_SYM_SPEED : `CCE_SYM_ANGLE;
		disp_r_next = {3'h0, item_reg[2:1]};
	end
	`CCE_S_DIGIT: begin
		disp_l_next = `CCE_SYM_BLANK;
		disp_r_next = {1'b0, cand_reg};
	end
	`CCE_S_ERROR: begin
		disp_l_next = `CCE_SYM_INVALID;
		disp_r_next = `CCE_SYM_INVALID;
	end
	`CCE_S_STORED: begin
		disp_l_next = `CCE_SYM_STORED;
		disp_r_next = `CCE_SYM_STORED;
	end
	default: begin
		disp_l_next = `CCE_SYM_BLANK;
		disp_r_next = `CCE_SYM_BLANK;
	end
	endcase
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		disp_left_reg <= `CCE_SYM_BLANK;
		disp_right_reg <= `CCE_SYM_BLANK;
		menu_busy_reg <= 1'b0;
	end else begin
		disp_left_reg <= disp_l_next;
		disp_right_reg <= disp_r_next;
		menu_busy_reg <= (state_reg != `CCE_S_IDLE);
	end
end

endmodule // cce_menu

// ---- tb/cce_magnet.sv ----
module cce_magnet #(
	parameter int HOLD = 12
) (
	input wire pclk,
	input wire presetn,
	input wire press_req,
	output wire mag_sw_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] cnt_reg;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt_reg <= 5'h00;
		else if (press_req)
			cnt_reg <= 5'h01;
		else if (cnt_reg != 5'h00)
			cnt_reg <= (cnt_reg == 5'(HOLD)) ? 5'h00 : cnt_reg + 5'h01;
	end
	// Contact bounces once at cnt 2; pull-up holds the line high between approaches
	assign mag_sw_n = !(cnt_reg != 5'h00 && cnt_reg != 5'h02);
endmodule // cce_magnet

// ---- tb/cce_menu_props.sv ----
module cce_menu_props (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata_reg,
	input wire pready_reg,
	input wire pslverr_reg,
	input wire [4:0] eng_disp_left,
	input wire [4:0] disp_left_reg,
	input wire menu_busy_reg,
	input wire nvm_commit_reg
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rdy; psel && !penable |=> pready_reg && penable; endproperty
	property p_once; pready_reg |=> !pready_reg; endproperty
	property p_err; pslverr_reg |-> pready_reg && prdata_reg == 32'h0; endproperty
	property p_slv; psel && !penable && paddr > 8'h18 |=> pslverr_reg; endproperty
	// Start only counts from idle, busy must follow within the state lag
	property p_start;
		psel && penable && pready_reg && pwrite && paddr == 8'h00 && pwdata[0]
		&& !menu_busy_reg |-> ##[1:3] menu_busy_reg;
	endproperty
	property p_hold; $rose(menu_busy_reg) |=> menu_busy_reg [*8]; endproperty
	property p_cpulse; nvm_commit_reg |=> !nvm_commit_reg; endproperty
	property p_cbusy; nvm_commit_reg |-> menu_busy_reg; endproperty
	property p_idle;
		!menu_busy_reg ##1 !menu_busy_reg |-> disp_left_reg == $past(eng_disp_left);
	endproperty
	a_rdy: assert property (p_rdy) else $error("pready missing in access");
	a_once: assert property (p_once) else $error("pready longer than one cycle");
	a_err: assert property (p_err) else $error("pslverr without pready or with data");
	a_slv: assert property (p_slv) else $error("unmapped access not refused");
	a_start: assert property (p_start) else $error("start did not raise busy");
	a_hold: assert property (p_hold) else $error("busy dropped early");
	a_cpulse: assert property (p_cpulse) else $error("commit longer than a pulse");
	a_cbusy: assert property (p_cbusy) else $error("commit outside edit");
	a_idle: assert property (p_idle) else $error("idle display not engine speed");
	c_commit: cover property (nvm_commit_reg);
	c_slverr: cover property (pslverr_reg);
	c_invalid: cover property (disp_left_reg == 5'h0C);
endmodule // cce_menu_props

bind cce_menu cce_menu_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata_reg(prdata_reg), .pready_reg(pready_reg), .pslverr_reg(pslverr_reg),
	.eng_disp_left(eng_disp_left), .disp_left_reg(disp_left_reg),
	.menu_busy_reg(menu_busy_reg), .nvm_commit_reg(nvm_commit_reg));

// ---- tb/tb_cce_menu.sv ----
module tb_cce_menu;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SLOT = 40;
	localparam int SHOW = 20;
	localparam int PRE[8] = '{32'h0, 32'h0A, 32'h28, 32'h14, 32'h64, 32'h1C, 32'hC8, 32'h19};
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, press_req = 0, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd;
	logic [4:0] eng_l = 5'h00;
	// Idle right digit kept out of the menu codes so no wait matches it early
	logic [4:0] eng_r = 5'h10;
	logic [15:0] lf = 16'hA237;
	wire [31:0] prdata_reg;
	wire pready_reg, pslverr_reg, mag_sw_n, menu_busy_reg, nvm_commit_reg;
	wire [4:0] disp_left_reg, disp_right_reg;
	int n_mismatch = 0, checks_done = 0, cyc = 0, i, c, v, k;
	int ex[3][5] = '{'{5{32'h0}}, '{5{32'h0A}}, '{5{32'h28}}};
	int act[3] = '{32'h0, 32'h0A, 32'h28};
	int vals[7] = '{32'h0D, 32'h27, 32'h26, 32'h0, 32'h0, 32'h0, 32'h64};
	cce_menu #(.SLOT_CYC(SLOT), .SHOW_CYC(SHOW), .DEB_CYC(4)) dut_u (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata_reg(prdata_reg), .pready_reg(pready_reg),
		.pslverr_reg(pslverr_reg), .mag_sw_n(mag_sw_n), .eng_disp_left(eng_l),
		.eng_disp_right(eng_r), .disp_left_reg(disp_left_reg),
		.disp_right_reg(disp_right_reg), .menu_busy_reg(menu_busy_reg),
		.nvm_commit_reg(nvm_commit_reg));
	cce_magnet mag_u (.pclk(pclk), .presetn(presetn), .press_req(press_req),
		.mag_sw_n(mag_sw_n));
	always #5 pclk = ~pclk;
	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready_reg !== 1'b1) @(posedge pclk);
		rd = prdata_reg;
		err = pslverr_reg;
		psel <= 0;
		penable <= 0;
	endtask
	task press;
		@(posedge pclk);
		press_req <= 1;
		@(posedge pclk);
		press_req <= 0;
		repeat (16) @(posedge pclk);
	endtask
	task wait_d(input logic [4:0] d, input int n, input logic both);
		int t;
		t = 0;
		while (disp_right_reg !== d && !(both && disp_left_reg === d) && t < n) begin
			@(negedge pclk);
			t++;
		end
		chk(t < n, 1);
	endtask
	task wait_lr(input logic [4:0] l, input logic [4:0] r, input int n);
		int t;
		t = 0;
		while (!(disp_left_reg === l && disp_right_reg === r) && t < n) begin
			@(negedge pclk);
			t++;
		end
		chk(t < n, 1);
	endtask
	task wait_idle(input int n);
		k = 0;
		// Busy lags the start write, so wait for it to rise before timing it
		while (menu_busy_reg !== 1'b1 && k < n) begin
			@(negedge pclk);
			k++;
		end
		k = 0;
		while (menu_busy_reg !== 1'b0 && k < n) begin
			@(negedge pclk);
			k++;
		end
	endtask
	task edit(input int c, input int it, input int v, input logic ab);
		int ncom, nerr, dv;
		logic ok;
		ok = (it == 1) ? v < 39 : (v > PRE[0] && v < PRE[4]);
		apb(1, 8'h00, 32'h1);
		wait_d(5'(c), 5 * SLOT, 0);
		press;
		if (ab) begin
			wait_lr(5'(ex[1][c] / 10), 5'(ex[1][c] % 10), 8 * SHOW);
			press;
			wait_d(5'h0B, SLOT, 1);
		end else begin
			wait_d(5'h0B, 1200, 1);
		end
		wait_d((it == 1) ? 5'h0F : 5'h0E, SHOW + 2 * SLOT, 1);
		press;
		dv = (it == 1) ? 10 : 100;
		while (dv > 0) begin
			wait_d(5'((v / dv) % 10), 11 * SLOT, 0);
			press;
			dv = dv / 10;
		end
		ncom = 0;
		nerr = 0;
		k = 0;
		// Commit and error symbol watched over the whole tail of the run
		while (menu_busy_reg !== 1'b0 && k < 6000) begin
			@(negedge pclk);
			k++;
			ncom += (nvm_commit_reg === 1'b1);
			nerr |= (disp_left_reg === 5'h0C);
		end
		chk(ncom, ok);
		chk(nerr, !ok);
		apb(0, 8'h04, 32'h0);
		chk(rd[5], !ok);
		if (ok)
			ex[it][c] = v;
		apb(1, 8'h10, (it << 4) | c);
		apb(0, 8'h14, 32'h0);
		chk(rd, ex[it][c]);
		apb(0, 8'h18, 32'h0);
		chk(rd, act[it]);
		apb(1, 8'h08, 10 + c);
		act[1] = ex[1][c];
		act[2] = ex[2][c];
		apb(0, 8'h18, 32'h0);
		chk(rd, act[it]);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		eng_l <= 5'(cyc % 10);
		eng_r <= {1'b1, lf[3:0]};
		if (cyc == 40000) begin
			n_mismatch++;
			print_verdict;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1;
		apb(0, 8'h04, 32'h0);
		chk(rd, 32'h0);
		apb(0, 8'h08, 32'h0);
		chk(rd, 32'h1);
		for (c = 0; c < 5; c++) begin
			for (i = 0; i < 8; i++) begin
				apb(1, 8'h10, (i << 4) | c);
				apb(0, 8'h14, 32'h0);
				chk(rd, PRE[i]);
			end
		end
		apb(0, 8'h1C, 32'h0);
		chk(rd, 32'h0);
		chk(err, 1);
		// No press at all: every curve slot must run out before idle
		apb(1, 8'h00, 32'h1);
		wait_idle(8 * SLOT);
		chk(k >= 5 * SLOT && k < 6 * SLOT, 1);
		lf = nx(lf);
		vals[3] = lf % 40;
		lf = nx(lf);
		vals[4] = lf % 40;
		lf = nx(lf);
		vals[5] = lf % 150;
		// Odd runs cut the playback short at angle0
		for (i = 0; i < 7; i++) begin
			lf = nx(lf);
			edit(lf % 5, (i < 5) ? 1 : 2, vals[i], i[0]);
		end
		apb(1, 8'h00, 32'h2);
		for (c = 0; c < 5; c++) begin
			for (i = 1; i < 3; i++) begin
				apb(1, 8'h10, (i << 4) | c);
				apb(0, 8'h14, 32'h0);
				chk(rd, PRE[i]);
			end
		end
		print_verdict;
	end
endmodule // tb_cce_menu
